// >>> rtl/exec_pkg.sv
// Purpose: Shared constants and types for the execution slice
// Assumes: Instructions arrive already decoded
// Notes: Offsets are for the small control register port
package exec_pkg;
  // Status flag positions
  localparam int F_C = 0;
  localparam int F_Z = 1;
  localparam int F_N = 2;
  localparam int F_V = 3;
  localparam int F_S = 4;
  localparam int F_H = 5;
  localparam int F_T = 6;
  localparam int F_I = 7;
  // Values after reset
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'hFFFF;
  // Working register indices
  localparam logic [4:0] R0_IDX = 5'h00;
  localparam logic [4:0] X_LO = 5'h1A;
  localparam logic [4:0] Y_LO = 5'h1C;
  localparam logic [4:0] Z_LO = 5'h1E;
  // Control register offsets
  localparam logic [2:0] RA_STAT = 3'h0;
  localparam logic [2:0] RA_PCL = 3'h1;
  localparam logic [2:0] RA_PCH = 3'h2;
  localparam logic [2:0] RA_SPL = 3'h3;
  localparam logic [2:0] RA_SPH = 3'h4;
  localparam logic [2:0] RA_STATE = 3'h5;
  typedef enum logic [1:0] {
    PTR_X = 2'h0,
    PTR_Y = 2'h1,
    PTR_Z = 2'h2
  } ptr_t;
  typedef enum logic [5:0] {
    OP_NOP = 6'h00,
    OP_BRANCH_IF_IRQ_ON = 6'h01,
    OP_BRANCH_IF_IRQ_OFF = 6'h02,
    OP_IO_BIT_SET = 6'h03,
    OP_IO_BIT_CLEAR = 6'h04,
    OP_SHIFT_LEFT_LOGICAL = 6'h05,
    OP_SHIFT_RIGHT_LOGICAL = 6'h06,
    OP_ROTATE_LEFT_CARRY = 6'h07,
    OP_ROTATE_RIGHT_CARRY = 6'h08,
    OP_SHIFT_RIGHT_SIGNED = 6'h09,
    OP_NIBBLE_SWAP = 6'h0A,
    OP_FLAG_SET = 6'h0B,
    OP_FLAG_CLEAR = 6'h0C,
    OP_BIT_TO_TRANSFER_FLAG = 6'h0D,
    OP_TRANSFER_FLAG_TO_BIT = 6'h0E,
    OP_MOVE = 6'h0F,
    OP_REGISTER_PAIR_COPY = 6'h10,
    OP_LOAD_IMMEDIATE = 6'h11,
    OP_LOAD_IND = 6'h12,
    OP_LOAD_POST_INC = 6'h13,
    OP_LOAD_PRE_DEC = 6'h14,
    OP_LOAD_DISPLACED = 6'h15,
    OP_LOAD_DIRECT_DATA = 6'h16,
    OP_STORE_IND = 6'h17,
    OP_STORE_POST_INC = 6'h18,
    OP_STORE_PRE_DEC = 6'h19,
    OP_STORE_DISPLACED = 6'h1A,
    OP_STORE_DIRECT_DATA = 6'h1B,
    OP_PROGRAM_MEMORY_READ = 6'h1C,
    OP_PROGRAM_MEMORY_READ_RD = 6'h1D,
    OP_PROGRAM_MEMORY_READ_INC = 6'h1E,
    OP_IO_IN = 6'h1F,
    OP_IO_OUT = 6'h20,
    OP_PUSH = 6'h21,
    OP_POP = 6'h22,
    OP_INTERRUPTS_ON = 6'h23,
    OP_INTERRUPTS_OFF = 6'h24
  } op_t;
endpackage

// >>> rtl/exec_core.sv
// Purpose: Executes branches, bit, shift, flag and data transfer ops
// Assumes: Decoded fields are steady while INSTR_VALID is high
// Notes:
// Contract
// - Branch on interrupts on: PC gets PC+k+1 when I set, 1 or 2 cycles
// - Branch on interrupts off: PC gets PC+k+1 when I clear
// - I/O bit set forces one bit high, two cycles, no flags
// - I/O bit clear forces one bit low, two cycles, no flags
// - Left shift and rotate, one cycle, update Z C N V
// - Right shifts logical, rotate, signed, one cycle, update Z C N V
// - Bit store copies a register bit into T only
// - Bit load copies T into a register bit, flags kept
// - Flag set or clear drives exactly one flag in one cycle
// - Signed test and overflow forms touch only S or V
// - Post-increment load reads at pointer then bumps pointer, two cycles
// - Pre-decrement load drops pointer first then reads, two cycles
// - Post-increment store writes at pointer then bumps pointer
// - Pre-decrement store drops pointer first then writes
// - Displaced load reads pointer plus q, pointer kept
// - Displaced store writes pointer plus q, pointer kept
// - Direct load reads constant address k, two cycles
// - Direct store writes constant address k, two cycles
// - Program memory read by Z into R0 or Rd, optional Z+1, three cycles
// - Push writes Rr onto stack in two cycles, flags kept
// - Pop reads top stack byte into Rd in two cycles
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module exec_core #(
  parameter int PC_W = 16
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // Decoded instruction
  input wire logic INSTR_VALID,
  input wire logic [5:0] INSTR_OP,
  input wire logic [4:0] INSTR_RD,
  input wire logic [4:0] INSTR_RR,
  input wire logic [2:0] INSTR_BIT,
  input wire logic [1:0] INSTR_PTR,
  input wire logic [5:0] INSTR_Q,
  input wire logic [5:0] INSTR_PORT,
  input wire logic [15:0] INSTR_K,
  output logic INSTR_READY,
  output logic [PC_W-1:0] PC_VALUE,
  output logic [7:0] STATUS_FLAGS,
  // Data space
  output logic [15:0] DMEM_ADDR,
  output logic [7:0] DMEM_WDATA,
  output logic DMEM_WR,
  output logic DMEM_RD,
  input wire logic [7:0] DMEM_RDATA,
  // Program memory, word address
  output logic [14:0] PMEM_ADDR,
  output logic PMEM_RD,
  input wire logic [15:0] PMEM_RDATA,
  // I/O space, read data is location INSTR_PORT
  input wire logic [7:0] IO_RDATA,
  output logic [5:0] IO_WADDR,
  output logic [7:0] IO_WDATA,
  output logic IO_WR,
  // Control register port
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA
);
  if (PC_W < 8 || PC_W > 16) begin : g_bad
    $error("PC_W must be 8 to 16");
  end

  typedef enum logic [2:0] {
    ST_READY = 3'b001,
    ST_HOLD = 3'b010,
    ST_PMEM = 3'b100
  } state_t;

  state_t state_q, state_d;
  logic [7:0] regs_q [32];
  logic [7:0] status_q;
  logic [15:0] sp_q, sp_d;
  logic [PC_W-1:0] pc_q, pc_d, pc_inc, br_tgt;
  logic dph_q, pph_q, pm_hi_q;
  logic [4:0] ld_idx_q, pm_idx_q;
  logic acc, pm_op;
  logic [1:0] psel;
  logic [4:0] ptr_i;
  logic [7:0] mask, rd_v, rr_v, res, fl_d, fm, io_wd;
  logic [15:0] ptr_v, ptr_n, ea;
  logic res_we, pair_we, ptr_we, d_rd, d_wr, p_rd, io_wr, hold;
  logic sh, c_n, rd_msb, rd_lsb, rr_sel;

  // Load data in flight is forwarded to the next reader
  function automatic logic [7:0] rf(input logic [4:0] i);
    rf = (dph_q && i == ld_idx_q) ? DMEM_RDATA : regs_q[i];
  endfunction

  assign acc = INSTR_VALID && (state_q == ST_READY);
  assign pm_op = INSTR_OP >= exec_pkg::OP_PROGRAM_MEMORY_READ &&
                 INSTR_OP <= exec_pkg::OP_PROGRAM_MEMORY_READ_INC;
  assign psel = pm_op ? exec_pkg::PTR_Z : INSTR_PTR;
  assign ptr_i = (psel == exec_pkg::PTR_Z) ? exec_pkg::Z_LO :
                 (psel == exec_pkg::PTR_Y) ? exec_pkg::Y_LO : exec_pkg::X_LO;
  always_comb begin
    ptr_v = {rf(ptr_i + 5'h01), rf(ptr_i)};
    rd_v = rf(INSTR_RD);
    rr_v = rf(INSTR_RR);
  end
  assign mask = 8'h01 << INSTR_BIT;
  assign rd_msb = rd_v[7];
  assign rd_lsb = rd_v[0];
  assign rr_sel = |(rr_v & mask);
  assign pc_inc = pc_q + PC_W'(1);
  assign br_tgt = pc_inc + {{(PC_W-7){INSTR_K[6]}}, INSTR_K[6:0]};

  always_comb begin
    res = rd_v;
    res_we = 1'b0;
    pair_we = 1'b0;
    ptr_we = 1'b0;
    ptr_n = ptr_v;
    ea = ptr_v;
    fl_d = status_q;
    fm = 8'h00;
    pc_d = pc_inc;
    sp_d = sp_q;
    d_rd = 1'b0;
    d_wr = 1'b0;
    p_rd = 1'b0;
    io_wr = 1'b0;
    io_wd = rr_v;
    hold = 1'b0;
    sh = 1'b0;
    c_n = 1'b0;
    case (exec_pkg::op_t'(INSTR_OP))
      exec_pkg::OP_BRANCH_IF_IRQ_ON: begin
        if (status_q[exec_pkg::F_I]) begin
          pc_d = br_tgt;
          hold = 1'b1;
        end
      end
      exec_pkg::OP_BRANCH_IF_IRQ_OFF: begin
        if (!status_q[exec_pkg::F_I]) begin
          pc_d = br_tgt;
          hold = 1'b1;
        end
      end
      exec_pkg::OP_IO_BIT_SET: begin
        io_wd = IO_RDATA | mask;
        io_wr = 1'b1;
        hold = 1'b1;
      end
      exec_pkg::OP_IO_BIT_CLEAR: begin
        io_wd = IO_RDATA & ~mask;
        io_wr = 1'b1;
        hold = 1'b1;
      end
      exec_pkg::OP_SHIFT_LEFT_LOGICAL: begin
        res = {rd_v[6:0], 1'b0};
        c_n = rd_v[7];
        sh = 1'b1;
      end
      exec_pkg::OP_ROTATE_LEFT_CARRY: begin
        res = {rd_v[6:0], status_q[exec_pkg::F_C]};
        c_n = rd_v[7];
        sh = 1'b1;
      end
      exec_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
        res = {1'b0, rd_v[7:1]};
        c_n = rd_v[0];
        sh = 1'b1;
      end
      exec_pkg::OP_ROTATE_RIGHT_CARRY: begin
        res = {status_q[exec_pkg::F_C], rd_v[7:1]};
        c_n = rd_v[0];
        sh = 1'b1;
      end
      exec_pkg::OP_SHIFT_RIGHT_SIGNED: begin
        res = {rd_v[7], rd_v[7:1]};
        c_n = rd_v[0];
        sh = 1'b1;
      end
      exec_pkg::OP_NIBBLE_SWAP: begin
        res = {rd_v[3:0], rd_v[7:4]};
        res_we = 1'b1;
      end
      exec_pkg::OP_FLAG_SET: begin
        fl_d = status_q | mask;
        fm = mask;
      end
      exec_pkg::OP_FLAG_CLEAR: begin
        fl_d = status_q & ~mask;
        fm = mask;
      end
      exec_pkg::OP_BIT_TO_TRANSFER_FLAG: begin
        fl_d[exec_pkg::F_T] = rr_sel;
        fm[exec_pkg::F_T] = 1'b1;
      end
      exec_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
        res = status_q[exec_pkg::F_T] ? (rd_v | mask) : (rd_v & ~mask);
        res_we = 1'b1;
      end
      exec_pkg::OP_MOVE: begin
        res = rr_v;
        res_we = 1'b1;
      end
      exec_pkg::OP_REGISTER_PAIR_COPY: pair_we = 1'b1;
      exec_pkg::OP_LOAD_IMMEDIATE: begin
        res = INSTR_K[7:0];
        res_we = 1'b1;
      end
      exec_pkg::OP_LOAD_IND: begin
        d_rd = 1'b1;
        hold = 1'b1;
      end
      exec_pkg::OP_LOAD_POST_INC: begin
        ptr_n = ptr_v + 16'h0001;
        ptr_we = 1'b1;
        d_rd = 1'b1;
        hold = 1'b1;
      end
      exec_pkg::OP_LOAD_PRE_DEC: begin
        ea = ptr_v - 16'h0001;
        ptr_n = ea;
        ptr_we = 1'b1;
        d_rd = 1'b1;
        hold = 1'b1;
      end
      // pointer kept, X has no displaced form
      exec_pkg::OP_LOAD_DISPLACED: begin
        if (INSTR_PTR != exec_pkg::PTR_X) begin
          ea = ptr_v + {10'h000, INSTR_Q};
          d_rd = 1'b1;
          hold = 1'b1;
        end
      end
      exec_pkg::OP_LOAD_DIRECT_DATA: begin
        ea = INSTR_K;
        pc_d = pc_q + PC_W'(2);
        d_rd = 1'b1;
        hold = 1'b1;
      end
      exec_pkg::OP_STORE_IND: begin
        d_wr = 1'b1;
        hold = 1'b1;
      end
      exec_pkg::OP_STORE_POST_INC: begin
        ptr_n = ptr_v + 16'h0001;
        ptr_we = 1'b1;
        d_wr = 1'b1;
        hold = 1'b1;
      end
      exec_pkg::OP_STORE_PRE_DEC: begin
        ea = ptr_v - 16'h0001;
        ptr_n = ea;
        ptr_we = 1'b1;
        d_wr = 1'b1;
        hold = 1'b1;
      end
      exec_pkg::OP_STORE_DISPLACED: begin
        if (INSTR_PTR != exec_pkg::PTR_X) begin
          ea = ptr_v + {10'h000, INSTR_Q};
          d_wr = 1'b1;
          hold = 1'b1;
        end
      end
      exec_pkg::OP_STORE_DIRECT_DATA: begin
        ea = INSTR_K;
        pc_d = pc_q + PC_W'(2);
        d_wr = 1'b1;
        hold = 1'b1;
      end
      exec_pkg::OP_PROGRAM_MEMORY_READ: p_rd = 1'b1;
      exec_pkg::OP_PROGRAM_MEMORY_READ_RD: p_rd = 1'b1;
      exec_pkg::OP_PROGRAM_MEMORY_READ_INC: begin
        ptr_n = ptr_v + 16'h0001;
        ptr_we = 1'b1;
        p_rd = 1'b1;
      end
      exec_pkg::OP_IO_IN: begin
        res = IO_RDATA;
        res_we = 1'b1;
      end
      exec_pkg::OP_IO_OUT: io_wr = 1'b1;
      exec_pkg::OP_PUSH: begin
        ea = sp_q;
        sp_d = sp_q - 16'h0001;
        d_wr = 1'b1;
        hold = 1'b1;
      end
      exec_pkg::OP_POP: begin
        ea = sp_q + 16'h0001;
        sp_d = ea;
        d_rd = 1'b1;
        hold = 1'b1;
      end
      exec_pkg::OP_INTERRUPTS_ON: begin
        fl_d[exec_pkg::F_I] = 1'b1;
        fm[exec_pkg::F_I] = 1'b1;
      end
      exec_pkg::OP_INTERRUPTS_OFF: begin
        fl_d[exec_pkg::F_I] = 1'b0;
        fm[exec_pkg::F_I] = 1'b1;
      end
      default: begin
      end
    endcase
    if (sh) begin
      res_we = 1'b1;
      fl_d[exec_pkg::F_C] = c_n;
      fl_d[exec_pkg::F_Z] = (res == 8'h00);
      fl_d[exec_pkg::F_N] = res[7];
      fl_d[exec_pkg::F_V] = res[7] ^ c_n;
      fm = 8'h0F;
    end
  end

  always_comb begin
    unique case (state_q)
      ST_READY: begin
        if (acc && p_rd) begin
          state_d = ST_PMEM;
        end else if (acc && hold) begin
          state_d = ST_HOLD;
        end else begin
          state_d = ST_READY;
        end
      end
      ST_PMEM: state_d = ST_HOLD;
      ST_HOLD: state_d = ST_READY;
      default: state_d = ST_READY;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_READY;
      INSTR_READY <= 1'b1;
    end else begin
      state_q <= state_d;
      INSTR_READY <= (state_d == ST_READY);
    end
  end

  // Newer instruction result overrides a late load landing
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < 32; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else begin
      if (dph_q) begin
        regs_q[ld_idx_q] <= DMEM_RDATA;
      end
      if (pph_q) begin
        regs_q[pm_idx_q] <= pm_hi_q ? PMEM_RDATA[15:8] : PMEM_RDATA[7:0];
      end
      if (acc && ptr_we) begin
        regs_q[ptr_i] <= ptr_n[7:0];
        regs_q[ptr_i + 5'h01] <= ptr_n[15:8];
      end
      if (acc && res_we) begin
        regs_q[INSTR_RD] <= res;
      end
      if (acc && pair_we) begin
        regs_q[{INSTR_RD[4:1], 1'b0}] <= rf({INSTR_RR[4:1], 1'b0});
        regs_q[{INSTR_RD[4:1], 1'b1}] <= rf({INSTR_RR[4:1], 1'b1});
      end
    end
  end

  // Instruction bits win over a software write in the same cycle
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      status_q <= exec_pkg::STAT_RST;
    end else if (REG_WR && REG_ADDR == exec_pkg::RA_STAT) begin
      status_q <= acc ? ((REG_WDATA & ~fm) | (fl_d & fm)) : REG_WDATA;
    end else if (acc) begin
      status_q <= (status_q & ~fm) | (fl_d & fm);
    end
  end
  assign STATUS_FLAGS = status_q;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pc_q <= exec_pkg::PC_RST[PC_W-1:0];
    end else if (acc) begin
      pc_q <= pc_d;
    end
  end
  assign PC_VALUE = pc_q;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      sp_q <= exec_pkg::SP_RST;
    end else if (acc && sp_d != sp_q) begin
      sp_q <= sp_d;
    end else if (REG_WR && REG_ADDR == exec_pkg::RA_SPL) begin
      sp_q <= {sp_q[15:8], REG_WDATA};
    end else if (REG_WR && REG_ADDR == exec_pkg::RA_SPH) begin
      sp_q <= {REG_WDATA, sp_q[7:0]};
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      DMEM_RD <= 1'b0;
      DMEM_WR <= 1'b0;
      DMEM_ADDR <= 16'h0000;
      DMEM_WDATA <= 8'h00;
      dph_q <= 1'b0;
      ld_idx_q <= 5'h00;
    end else begin
      DMEM_RD <= acc && d_rd;
      DMEM_WR <= acc && d_wr;
      dph_q <= DMEM_RD;
      if (acc && (d_rd || d_wr)) begin
        DMEM_ADDR <= ea;
        DMEM_WDATA <= rr_v;
        ld_idx_q <= INSTR_RD;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      PMEM_RD <= 1'b0;
      PMEM_ADDR <= 15'h0000;
      pph_q <= 1'b0;
      pm_hi_q <= 1'b0;
      pm_idx_q <= 5'h00;
    end else begin
      PMEM_RD <= acc && p_rd;
      pph_q <= PMEM_RD;
      if (acc && p_rd) begin
        PMEM_ADDR <= ptr_v[15:1];
        pm_hi_q <= ptr_v[0];
        pm_idx_q <= (INSTR_OP == exec_pkg::OP_PROGRAM_MEMORY_READ) ? exec_pkg::R0_IDX : INSTR_RD;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      IO_WR <= 1'b0;
      IO_WADDR <= 6'h00;
      IO_WDATA <= 8'h00;
    end else begin
      IO_WR <= acc && io_wr;
      if (acc && io_wr) begin
        IO_WADDR <= INSTR_PORT;
        IO_WDATA <= io_wd;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        exec_pkg::RA_STAT: REG_RDATA <= status_q;
        exec_pkg::RA_PCL: REG_RDATA <= 8'(pc_q);
        exec_pkg::RA_PCH: REG_RDATA <= 8'(16'(pc_q) >> 8);
        exec_pkg::RA_SPL: REG_RDATA <= sp_q[7:0];
        exec_pkg::RA_SPH: REG_RDATA <= sp_q[15:8];
        exec_pkg::RA_STATE: REG_RDATA <= {5'h00, state_q};
        default: REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  irq_on_branch_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    acc && INSTR_OP == exec_pkg::OP_BRANCH_IF_IRQ_ON && status_q[exec_pkg::F_I]
    |=> PC_VALUE == $past(br_tgt) && !INSTR_READY ##1 INSTR_READY)
    else $error("taken branch target or length wrong");
  irq_off_branch_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    acc && INSTR_OP == exec_pkg::OP_BRANCH_IF_IRQ_OFF && status_q[exec_pkg::F_I]
    |=> PC_VALUE == $past(pc_inc) && INSTR_READY)
    else $error("untaken branch not one cycle");
  io_set_rmw_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    acc && INSTR_OP == exec_pkg::OP_IO_BIT_SET
    |=> IO_WR && IO_WDATA == ($past(IO_RDATA) | $past(mask)) && !INSTR_READY)
    else $error("io bit set wrong");
  io_clear_rmw_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    acc && INSTR_OP == exec_pkg::OP_IO_BIT_CLEAR
    |=> IO_WR && IO_WDATA == ($past(IO_RDATA) & ~$past(mask)) ##1 !IO_WR)
    else $error("io bit clear wrong");
  shl_carry_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    acc && INSTR_OP == exec_pkg::OP_SHIFT_LEFT_LOGICAL
    |=> status_q[exec_pkg::F_C] == $past(rd_msb) &&
        status_q[exec_pkg::F_V] == (status_q[exec_pkg::F_N] ^ status_q[exec_pkg::F_C]))
    else $error("left shift flags wrong");
  shr_carry_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    acc && INSTR_OP == exec_pkg::OP_SHIFT_RIGHT_LOGICAL
    |=> status_q[exec_pkg::F_C] == $past(rd_lsb) && !status_q[exec_pkg::F_N])
    else $error("right shift flags wrong");
  t_flag_store_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    acc && INSTR_OP == exec_pkg::OP_BIT_TO_TRANSFER_FLAG && !REG_WR
    |=> status_q[exec_pkg::F_T] == $past(rr_sel) &&
        ((status_q ^ $past(status_q)) & 8'hBF) == 8'h00)
    else $error("bit store touched other flags");
  flag_one_bit_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    acc && INSTR_OP == exec_pkg::OP_FLAG_SET && !REG_WR
    |=> status_q == ($past(status_q) | $past(mask)))
    else $error("flag set changed wrong bits");
  post_inc_read_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    acc && INSTR_OP == exec_pkg::OP_LOAD_POST_INC
    |=> DMEM_RD && DMEM_ADDR == $past(ptr_v) && !INSTR_READY ##1 !DMEM_RD && INSTR_READY)
    else $error("post increment load wrong");
  pre_dec_read_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    acc && INSTR_OP == exec_pkg::OP_LOAD_PRE_DEC
    |=> DMEM_RD && DMEM_ADDR == $past(ptr_v) - 16'h0001)
    else $error("pre decrement address wrong");
  pm_read_len_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    acc && p_rd |=> PMEM_RD && !INSTR_READY ##1 !PMEM_RD && !INSTR_READY ##1 INSTR_READY)
    else $error("program read not three cycles");
  push_stack_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    acc && INSTR_OP == exec_pkg::OP_PUSH
    |=> DMEM_WR && DMEM_ADDR == $past(sp_q) && sp_q == $past(sp_q) - 16'h0001)
    else $error("push address or stack pointer wrong");
  irq_flag_on_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    acc && INSTR_OP == exec_pkg::OP_INTERRUPTS_ON |=> status_q[exec_pkg::F_I])
    else $error("interrupts on did not set I");
endmodule
`default_nettype wire

// >>> test/mem_model.sv
// Purpose: Data, program and I/O space model
// Assumes: 256 data bytes, 64 I/O places
// Notes: Idle read lines show inverted last data
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // Clock
  input wire logic CLK_SYS,
  // Data space
  input wire logic [15:0] DMEM_ADDR,
  input wire logic [7:0] DMEM_WDATA,
  input wire logic DMEM_WR,
  input wire logic DMEM_RD,
  output logic [7:0] DMEM_RDATA,
  // Program memory
  input wire logic [14:0] PMEM_ADDR,
  input wire logic PMEM_RD,
  output logic [15:0] PMEM_RDATA,
  // I/O space
  input wire logic [5:0] INSTR_PORT,
  output logic [7:0] IO_RDATA,
  input wire logic [5:0] IO_WADDR,
  input wire logic [7:0] IO_WDATA,
  input wire logic IO_WR
);
  logic [7:0] dmem [256];
  logic [7:0] io [64];
  logic [7:0] dq = 8'h00;
  logic [15:0] pq = 16'h0000;
  logic drd_q = 1'h0;
  logic prd_q = 1'h0;
  initial for (int i = 0; i < 64; i++) io[i] = i[7:0];
  // Data stands only the cycle after a strobe
  always @(posedge CLK_SYS) begin
    drd_q <= DMEM_RD;
    prd_q <= PMEM_RD;
    if (DMEM_RD) dq <= dmem[DMEM_ADDR[7:0]];
    if (PMEM_RD) pq <= {~PMEM_ADDR[7:0], PMEM_ADDR[7:0]};
    if (DMEM_WR) dmem[DMEM_ADDR[7:0]] <= DMEM_WDATA;
    if (IO_WR) io[IO_WADDR] <= IO_WDATA;
  end
  assign DMEM_RDATA = drd_q ? dq : ~dq;
  assign PMEM_RDATA = prd_q ? pq : ~pq;
  assign IO_RDATA = io[INSTR_PORT];
endmodule
`default_nettype wire

// >>> test/bit_flag_data_transfer_exec_tb.sv
// Purpose: Self-checking bench for exec_core
// Assumes: Registers seen through I/O output
// Notes: One instruction at a time
`timescale 1ns/1ps
`default_nettype none
module bit_flag_data_transfer_exec_tb;
  logic CLK_SYS = 0, RESETN = 0, INSTR_VALID = 0, REG_WR = 0, REG_RD = 0;
  logic INSTR_READY, DMEM_WR, DMEM_RD, PMEM_RD, IO_WR;
  logic [5:0] INSTR_OP = 0, INSTR_Q = 0, INSTR_PORT = 0, IO_WADDR;
  logic [4:0] INSTR_RD = 0, INSTR_RR = 0;
  logic [2:0] INSTR_BIT = 0, REG_ADDR = 0;
  logic [1:0] INSTR_PTR = 0;
  logic [15:0] INSTR_K = 0, PC_VALUE, DMEM_ADDR, PMEM_RDATA, pc;
  logic [7:0] STATUS_FLAGS, DMEM_WDATA, DMEM_RDATA, IO_RDATA, IO_WDATA, REG_RDATA, v, st;
  logic [7:0] REG_WDATA = 0;
  logic [14:0] PMEM_ADDR;
  int n_errors = 0, num_checks = 0;
  always #25 CLK_SYS = ~CLK_SYS;
  exec_core exec_core_i (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .INSTR_VALID(INSTR_VALID),
    .INSTR_OP(INSTR_OP), .INSTR_RD(INSTR_RD), .INSTR_RR(INSTR_RR), .INSTR_BIT(INSTR_BIT),
    .INSTR_PTR(INSTR_PTR), .INSTR_Q(INSTR_Q), .INSTR_PORT(INSTR_PORT), .INSTR_K(INSTR_K),
    .INSTR_READY(INSTR_READY), .PC_VALUE(PC_VALUE), .STATUS_FLAGS(STATUS_FLAGS),
    .DMEM_ADDR(DMEM_ADDR), .DMEM_WDATA(DMEM_WDATA), .DMEM_WR(DMEM_WR), .DMEM_RD(DMEM_RD),
    .DMEM_RDATA(DMEM_RDATA), .PMEM_ADDR(PMEM_ADDR), .PMEM_RD(PMEM_RD), .PMEM_RDATA(PMEM_RDATA),
    .IO_RDATA(IO_RDATA), .IO_WADDR(IO_WADDR), .IO_WDATA(IO_WDATA), .IO_WR(IO_WR),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
  mem_model mem_model_i (.CLK_SYS(CLK_SYS), .DMEM_ADDR(DMEM_ADDR), .DMEM_WDATA(DMEM_WDATA),
    .DMEM_WR(DMEM_WR), .DMEM_RD(DMEM_RD), .DMEM_RDATA(DMEM_RDATA), .PMEM_ADDR(PMEM_ADDR),
    .PMEM_RD(PMEM_RD), .PMEM_RDATA(PMEM_RDATA), .INSTR_PORT(INSTR_PORT), .IO_RDATA(IO_RDATA),
    .IO_WADDR(IO_WADDR), .IO_WDATA(IO_WDATA), .IO_WR(IO_WR));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ex(input logic [5:0] op, input logic [4:0] d = 0, input logic [4:0] r = 0,
                    input logic [15:0] k = 0, input logic [2:0] b = 0, input logic [5:0] p = 0);
    @(posedge CLK_SYS);
    INSTR_VALID <= 1'h1;
    INSTR_OP <= op;
    INSTR_RD <= d;
    INSTR_RR <= r;
    INSTR_K <= k;
    INSTR_BIT <= b;
    INSTR_PORT <= p;
    INSTR_Q <= p;
    INSTR_PTR <= p[1:0];
    do @(negedge CLK_SYS); while (INSTR_READY !== 1'h1);
    @(posedge CLK_SYS);
    INSTR_VALID <= 1'h0;
    @(negedge CLK_SYS);
  endtask
  task automatic out(input logic [4:0] r, input logic [7:0] e);
    ex(exec_pkg::OP_IO_OUT, 5'h00, r, 16'h0000, 3'h0, 6'h05);
    chk("out", {8'h85, e}, {IO_WR, 1'h0, IO_WADDR, IO_WDATA});
  endtask
  task automatic rr(input logic [2:0] a);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_RD <= 1'h1;
    @(posedge CLK_SYS);
    REG_RD <= 1'h0;
    @(negedge CLK_SYS);
    v = REG_RDATA;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (400) @(posedge CLK_SYS);
    n_errors++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge CLK_SYS);
    RESETN <= 1'h1;
    ex(exec_pkg::OP_LOAD_IMMEDIATE, 5'h10, 5'h00, 16'h0081);
    ex(exec_pkg::OP_SHIFT_LEFT_LOGICAL, 5'h10);
    chk("lsl", 16'h0009, STATUS_FLAGS);
    ex(exec_pkg::OP_ROTATE_RIGHT_CARRY, 5'h10);
    chk("ror", 16'h000C, STATUS_FLAGS);
    ex(exec_pkg::OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h10, 16'h0000, 3'h7);
    chk("bst", 16'h004C, STATUS_FLAGS);
    ex(exec_pkg::OP_TRANSFER_FLAG_TO_BIT, 5'h10, 5'h00, 16'h0000, 3'h3);
    chk("bld", 16'h004C, STATUS_FLAGS);
    out(5'h10, 8'h89);
    $display("shift test done");
    st = 8'h4C;
    for (int s = 0; s < 8; s++) begin
      ex(exec_pkg::OP_FLAG_SET, 5'h00, 5'h00, 16'h0000, s[2:0]);
      st[s] = 1'h1;
      chk("set", {8'h00, st}, STATUS_FLAGS);
      ex(exec_pkg::OP_FLAG_CLEAR, 5'h00, 5'h00, 16'h0000, s[2:0]);
      st[s] = 1'h0;
      chk("clr", {8'h00, st}, STATUS_FLAGS);
    end
    $display("flag test done");
    pc = PC_VALUE;
    ex(exec_pkg::OP_BRANCH_IF_IRQ_ON, 5'h00, 5'h00, 16'h0005);
    chk("branch_if_irq_on_n", pc + 16'h0001, PC_VALUE);
    ex(exec_pkg::OP_BRANCH_IF_IRQ_OFF, 5'h00, 5'h00, 16'h007E);
    chk("branch_if_irq_off_t", pc, PC_VALUE);
    ex(exec_pkg::OP_INTERRUPTS_ON);
    chk("ion", 16'h0080, STATUS_FLAGS);
    ex(exec_pkg::OP_BRANCH_IF_IRQ_ON, 5'h00, 5'h00, 16'h0003);
    chk("branch_if_irq_on_t", pc + 16'h0005, PC_VALUE);
    ex(exec_pkg::OP_BRANCH_IF_IRQ_OFF, 5'h00, 5'h00, 16'h0003);
    chk("branch_if_irq_off_n", pc + 16'h0006, PC_VALUE);
    ex(exec_pkg::OP_INTERRUPTS_OFF);
    chk("ioff", 16'h0000, STATUS_FLAGS);
    $display("branch test done");
    ex(exec_pkg::OP_LOAD_IMMEDIATE, 5'h1A, 5'h00, 16'h0010);
    ex(exec_pkg::OP_LOAD_IMMEDIATE, 5'h1B);
    ex(exec_pkg::OP_LOAD_IMMEDIATE, 5'h11, 5'h00, 16'h005A);
    ex(exec_pkg::OP_STORE_POST_INC, 5'h00, 5'h11);
    chk("st", 16'h015A, {7'h00, DMEM_WR, DMEM_WDATA});
    chk("st_a", 16'h0010, DMEM_ADDR);
    ex(exec_pkg::OP_LOAD_PRE_DEC, 5'h12);
    chk("ld_a", 16'h0010, DMEM_ADDR);
    out(5'h12, 8'h5A);
    ex(exec_pkg::OP_PUSH, 5'h00, 5'h11);
    chk("push_a", 16'hFFFF, DMEM_ADDR);
    rr(exec_pkg::RA_SPL);
    chk("sp", 16'h00FE, v);
    ex(exec_pkg::OP_POP, 5'h14);
    out(5'h14, 8'h5A);
    rr(3'h7);
    chk("unmapped", 16'h0000, v);
    $display("data test done");
    ex(exec_pkg::OP_LOAD_IMMEDIATE, 5'h1E, 5'h00, 16'h0041);
    ex(exec_pkg::OP_LOAD_IMMEDIATE, 5'h1F);
    ex(exec_pkg::OP_PROGRAM_MEMORY_READ_INC, 5'h13);
    ex(exec_pkg::OP_PROGRAM_MEMORY_READ);
    out(5'h13, 8'hDF);
    out(5'h00, 8'h21);
    ex(exec_pkg::OP_IO_BIT_SET, 5'h00, 5'h00, 16'h0000, 3'h2, 6'h03);
    chk("sbi", 16'h0107, {7'h00, IO_WR, IO_WDATA});
    ex(exec_pkg::OP_IO_BIT_CLEAR, 5'h00, 5'h00, 16'h0000, 3'h0, 6'h03);
    chk("cbi", 16'h0106, {7'h00, IO_WR, IO_WDATA});
    ex(exec_pkg::OP_SHIFT_RIGHT_LOGICAL, 5'h10);
    chk("lsr", 16'h0009, STATUS_FLAGS);
    ex(exec_pkg::OP_SHIFT_RIGHT_SIGNED, 5'h13);
    chk("asr", 16'h0005, STATUS_FLAGS);
    ex(exec_pkg::OP_ROTATE_LEFT_CARRY, 5'h11);
    chk("rol", 16'h000C, STATUS_FLAGS);
    ex(exec_pkg::OP_NIBBLE_SWAP, 5'h11);
    ex(exec_pkg::OP_REGISTER_PAIR_COPY, 5'h03, 5'h11);
    ex(exec_pkg::OP_MOVE, 5'h15, 5'h13);
    chk("keep", 16'h000C, STATUS_FLAGS);
    out(5'h03, 8'h5B);
    out(5'h15, 8'hEF);
    ex(exec_pkg::OP_IO_IN, 5'h16, 5'h00, 16'h0000, 3'h0, 6'h03);
    out(5'h16, 8'h06);
    ex(exec_pkg::OP_STORE_DISPLACED, 5'h00, 5'h11, 16'h0000, 3'h0, 6'h11);
    ex(exec_pkg::OP_LOAD_DISPLACED, 5'h17, 5'h00, 16'h0000, 3'h0, 6'h11);
    out(5'h17, 8'h5B);
    ex(exec_pkg::OP_STORE_DIRECT_DATA, 5'h00, 5'h10, 16'h0030);
    ex(exec_pkg::OP_LOAD_DIRECT_DATA, 5'h18, 5'h00, 16'h0030);
    out(5'h18, 8'h44);
    ex(exec_pkg::OP_LOAD_POST_INC, 5'h19);
    chk("ld_p", 16'h8010, {DMEM_RD, DMEM_ADDR[14:0]});
    ex(exec_pkg::OP_STORE_PRE_DEC, 5'h00, 5'h19);
    chk("st_m", 16'h5A10, {DMEM_WDATA, DMEM_ADDR[7:0]});
    ex(exec_pkg::OP_PROGRAM_MEMORY_READ_RD, 5'h01);
    chk("pm_a", 16'h8021, {PMEM_RD, PMEM_ADDR});
    out(5'h01, 8'h21);
    $display("program and io test done");
    test_done();
  end
endmodule
`default_nettype wire
